/* File: logic/crsf_pkg.sv */
/*
 * Constants and types for the CPU register set and condition flags.
 * Assumes one 40 MHz clock shared by core, memory and bus slave.
 */
package crsf_pkg;
	localparam logic [15:0] SP_RESET    = 16'h00ff;
	localparam logic [7:0]  SP_LOW_SET  = 8'hff;
	localparam logic [15:0] VEC_RESET   = 16'hfffe;
	localparam logic [15:0] VEC_IRQ_TOP = 16'hfffc;
	localparam logic [15:0] PC_RESET    = 16'h0000;
	localparam int CC_V = 7;
	localparam int CC_H = 4;
	localparam int CC_I = 3;
	localparam int CC_N = 2;
	localparam int CC_Z = 1;
	localparam int CC_C = 0;
	localparam logic [7:0] CC_FIXED = 8'h60;
	localparam logic [7:0] CC_RESET = 8'h68;
	localparam logic [2:0] REG_ACC = 3'h0;
	localparam logic [2:0] REG_XLO = 3'h1;
	localparam logic [2:0] REG_XHI = 3'h2;
	localparam logic [2:0] REG_CC  = 3'h3;
	localparam logic [2:0] REG_SP  = 3'h4;
	localparam logic [2:0] REG_PC  = 3'h5;
	localparam logic [2:0] REG_STS = 3'h6;
	localparam logic [2:0] INT_PUSHES = 3'h5;

	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_RST  = 6'b000010,
		S_INT  = 6'b000100,
		S_RET  = 6'b001000,
		S_PSH  = 6'b010000,
		S_PUL  = 6'b100000
	} crsf_state_t;

	typedef enum logic [3:0] {
		OP_NOP, OP_ALU, OP_LDX, OP_LDH, OP_TAP, OP_SEI, OP_INT_EN,
		OP_SP_RESET, OP_PUSH, OP_PULL, OP_FETCH, OP_JUMP, OP_BRANCH,
		OP_EA_IX, OP_EA_SP, OP_RET_INT
	} crsf_kind_t;

	typedef enum logic [3:0] {
		FN_ADD, FN_ADC, FN_SUB, FN_SBC, FN_AND, FN_ORA, FN_EOR,
		FN_LDA, FN_ASL, FN_LSR, FN_ROL, FN_ROR, FN_DADJ
	} crsf_fn_t;

	typedef enum logic [1:0] {
		COND_ALWAYS, COND_SIGNED_GREATER, COND_SIGNED_LESS, COND_CARRY_CLR
	} crsf_cond_t;

	typedef enum logic [2:0] {
		SEL_A, SEL_X, SEL_H, SEL_CC, SEL_PCH, SEL_PCL
	} crsf_sel_t;

	typedef struct packed {
		crsf_kind_t  kind;
		crsf_fn_t    fn;
		crsf_cond_t  cond;
		crsf_sel_t   sel;
		logic [7:0]  data;
		logic [15:0] addr;
	} crsf_op_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} crsf_mem_req_t;

	typedef struct packed {
		logic [7:0]  acc;
		logic [15:0] hx;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [7:0]  cc;
	} crsf_regs_t;

	typedef struct packed {
		logic [7:0] r;
		logic [7:0] cc;
	} crsf_alu_t;
endpackage : crsf_pkg

/* File: logic/crsf_core.sv */
/*
 * CPU register set, condition flags and stack sequencer.
 * Assumes same-clock core commands, a memory that returns read data
 * the cycle after mem.rd, and an Avalon-MM master for debug access.
 */
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module crsf_core import crsf_pkg::*; #(
	parameter int  IRQ_N = 4,
	localparam int IW    = (IRQ_N > 1) ? $clog2(IRQ_N) : 1
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Avalon-MM slave
	input  wire logic [2:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	// Core command
	input  wire crsf_op_t          op,
	input  wire logic              op_valid,
	output logic                   op_ready,
	// Memory master
	output crsf_mem_req_t          mem,
	input  wire logic [7:0]        mem_rdata,
	// Interrupt requests
	input  wire logic [IRQ_N-1:0]  irq_pend,
	output logic                   irq_ack,
	output logic [IW-1:0]          irq_idx,
	// Register view
	output crsf_regs_t             regs,
	output logic [15:0]            ea
);
	crsf_state_t   st_q;
	crsf_sel_t     sel_q;
	logic [3:0]    step_q;
	logic [7:0]    acc_q;
	logic [7:0]    x_q;
	logic [7:0]    h_q;
	logic [7:0]    cc_q;
	logic [15:0]   sp_q;
	logic [15:0]   pc_q;
	logic [15:0]   vec_q;
	logic [15:0]   ea_q;
	logic [31:0]   rdata_q;
	logic          wait_q;
	logic          ready_q;
	logic          ack_q;
	logic [IW-1:0] idx_q;
	crsf_mem_req_t mem_q;

	function automatic crsf_alu_t alu_f(crsf_fn_t fn, logic [7:0] a,
			logic [7:0] m, logic [7:0] cc);
		logic [8:0] s;
		logic [7:0] corr;
		logic       cin;
		crsf_alu_t  o;
		s = 9'h000;
		corr = 8'h00;
		cin = (fn == FN_ADC || fn == FN_SBC) && cc[CC_C];
		o.r = a;
		o.cc = cc;
		unique case (fn)
			FN_ADD, FN_ADC: begin
				s = {1'b0, a} + {1'b0, m} + {8'h00, cin};
				o.r = s[7:0];
				o.cc[CC_C] = s[8];
				o.cc[CC_H] = (a[3] & m[3]) | (m[3] & ~s[3]) |
					(~s[3] & a[3]);
				o.cc[CC_V] = (a[7] & m[7] & ~s[7]) |
					(~a[7] & ~m[7] & s[7]);
			end
			FN_SUB, FN_SBC: begin
				s = {1'b0, a} - {1'b0, m} - {8'h00, cin};
				o.r = s[7:0];
				o.cc[CC_C] = s[8];
				o.cc[CC_V] = (a[7] & ~m[7] & ~s[7]) |
					(~a[7] & m[7] & s[7]);
			end
			FN_AND: o.r = a & m;
			FN_ORA: o.r = a | m;
			FN_EOR: o.r = a ^ m;
			FN_LDA: o.r = m;
			FN_ASL: {o.cc[CC_C], o.r} = {a, 1'b0};
			FN_LSR: {o.r, o.cc[CC_C]} = {1'b0, a};
			FN_ROL: {o.cc[CC_C], o.r} = {a, cc[CC_C]};
			FN_ROR: {o.r, o.cc[CC_C]} = {cc[CC_C], a};
			FN_DADJ: begin
				// Correction picked from H, C and the digits
				corr[3:0] = (cc[CC_H] || a[3:0] > 4'h9) ? 4'h6 : 4'h0;
				corr[7:4] = (cc[CC_C] || a > 8'h99) ? 4'h6 : 4'h0;
				o.r = a + corr;
				o.cc[CC_C] = cc[CC_C] | (a > 8'h99);
			end
			default: ;
		endcase
		if (fn inside {FN_AND, FN_ORA, FN_EOR, FN_LDA})
			o.cc[CC_V] = 1'b0;
		if (fn inside {FN_ASL, FN_LSR, FN_ROL, FN_ROR})
			o.cc[CC_V] = o.r[7] ^ o.cc[CC_C];
		o.cc[CC_N] = o.r[7];
		o.cc[CC_Z] = (o.r == 8'h00);
		return o;
	endfunction : alu_f

	function automatic logic cond_f(crsf_cond_t c, logic [7:0] cc);
		logic lt;
		lt = cc[CC_N] ^ cc[CC_V];
		unique case (c)
			COND_ALWAYS:         return 1'b1;
			COND_SIGNED_GREATER: return !(cc[CC_Z] | lt);
			COND_SIGNED_LESS:    return lt;
			COND_CARRY_CLR:      return !cc[CC_C];
		endcase
	endfunction : cond_f

	// Stack order: PCL PCH X A CC out, then vector high and low in
	function automatic crsf_sel_t seq_sel(crsf_state_t s, logic [2:0] j,
			crsf_sel_t sel);
		case (s)
			S_RST: return (j == 3'h0) ? SEL_PCH : SEL_PCL;
			S_INT: begin
				case (j)
					3'h0: return SEL_PCL;
					3'h1: return SEL_PCH;
					3'h2: return SEL_X;
					3'h3: return SEL_A;
					3'h4: return SEL_CC;
					3'h5: return SEL_PCH;
					default: return SEL_PCL;
				endcase
			end
			S_RET: begin
				case (j)
					3'h0: return SEL_CC;
					3'h1: return SEL_A;
					3'h2: return SEL_X;
					3'h3: return SEL_PCH;
					default: return SEL_PCL;
				endcase
			end
			default: return sel;
		endcase
	endfunction : seq_sel

	function automatic logic [15:0] be16(logic [15:0] o, logic [31:0] w,
			logic [3:0] be);
		return {be[1] ? w[15:8] : o[15:8], be[0] ? w[7:0] : o[7:0]};
	endfunction : be16

	// Sequencer decode
	logic          idle, even, issue, capture, finish, is_wr, is_pull;
	logic [2:0]    k, k_prev, n_acc;
	crsf_sel_t     iss_sel, cap_sel;
	logic [7:0]    iss_data;
	logic [15:0]   iss_addr;
	always_comb begin
		idle = (st_q == S_IDLE);
		k = step_q[3:1];
		k_prev = 3'(k - 3'h1);
		even = !step_q[0];
		unique case (st_q)
			S_RST:        n_acc = 3'h2;
			S_INT:        n_acc = 3'h7;
			S_RET:        n_acc = 3'h5;
			S_PSH, S_PUL: n_acc = 3'h1;
			default:      n_acc = 3'h0;
		endcase
		is_wr = (st_q == S_PSH) || (st_q == S_INT && k < INT_PUSHES);
		is_pull = (st_q == S_PUL) || (st_q == S_RET);
		issue = !idle && even && (k < n_acc);
		finish = !idle && even && (k == n_acc);
		capture = !idle && even && (k != 3'h0) && (st_q != S_PSH) &&
			!(st_q == S_INT && k <= INT_PUSHES);
		iss_sel = seq_sel(st_q, k, sel_q);
		cap_sel = seq_sel(st_q, k_prev, sel_q);
		unique case (iss_sel)
			SEL_A:   iss_data = acc_q;
			SEL_X:   iss_data = x_q;
			SEL_H:   iss_data = h_q;
			SEL_CC:  iss_data = cc_q;
			SEL_PCH: iss_data = pc_q[15:8];
			default: iss_data = pc_q[7:0];
		endcase
		if (st_q == S_RST)
			iss_addr = {VEC_RESET[15:1], k[0]};
		else if (st_q == S_INT && !is_wr)
			iss_addr = {vec_q[15:1], k == 3'h6};
		else if (is_pull)
			iss_addr = sp_q + 16'h0001;
		else
			iss_addr = sp_q;
	end

	// Handshake and arbitration
	logic      op_fire, irq_go, grant, bus_wr, nxt_idle;
	logic [IW-1:0] prio;
	crsf_alu_t alu;
	always_comb begin
		prio = '0;
		for (int i = IRQ_N - 1; i >= 0; i--)
			if (irq_pend[i])
				prio = IW'(i);
		op_fire = op_valid && ready_q;
		irq_go = idle && ready_q && !op_fire && !cc_q[CC_I] &&
			(|irq_pend);
		grant = (avs_read || avs_write) && wait_q && idle && !op_fire &&
			!irq_go;
		bus_wr = avs_write && !wait_q;
		nxt_idle = idle ? !(irq_go || (op_fire && op.kind inside
			{OP_PUSH, OP_PULL, OP_RET_INT})) : finish;
		alu = alu_f(op.fn, acc_q, op.data, cc_q);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q <= S_RST;
			step_q <= 4'h0;
			sel_q <= SEL_A;
		end else if (idle) begin
			if (irq_go)
				st_q <= S_INT;
			else if (op_fire && op.kind == OP_PUSH)
				st_q <= S_PSH;
			else if (op_fire && op.kind == OP_PULL)
				st_q <= S_PUL;
			else if (op_fire && op.kind == OP_RET_INT)
				st_q <= S_RET;
			if (op_fire)
				sel_q <= op.sel;
		end else if (finish) begin
			st_q <= S_IDLE;
			step_q <= 4'h0;
		end else begin
			step_q <= 4'(step_q + 4'h1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			ready_q <= 1'b0;
		end else begin
			wait_q <= !grant;
			ready_q <= nxt_idle && !grant;
			if (grant) begin
				unique case (avs_address)
					REG_ACC: rdata_q <= {24'h0, acc_q};
					REG_XLO: rdata_q <= {24'h0, x_q};
					REG_XHI: rdata_q <= {24'h0, h_q};
					REG_CC:  rdata_q <= {24'h0, cc_q | CC_FIXED};
					REG_SP:  rdata_q <= {16'h0, sp_q};
					REG_PC:  rdata_q <= {16'h0, pc_q};
					REG_STS: rdata_q <= 32'({irq_pend, 2'b00, st_q});
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			acc_q <= 8'h00;
		else if (bus_wr && avs_address == REG_ACC && avs_byteenable[0])
			acc_q <= avs_writedata[7:0];
		else if (capture && cap_sel == SEL_A)
			acc_q <= mem_rdata;
		else if (op_fire && op.kind == OP_ALU)
			acc_q <= alu.r;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			x_q <= 8'h00;
			h_q <= 8'h00;
		end else begin
			if (bus_wr && avs_address == REG_XLO && avs_byteenable[0])
				x_q <= avs_writedata[7:0];
			else if (capture && cap_sel == SEL_X)
				x_q <= mem_rdata;
			else if (op_fire && op.kind == OP_LDX)
				x_q <= op.data;
			if (bus_wr && avs_address == REG_XHI && avs_byteenable[0])
				h_q <= avs_writedata[7:0];
			else if (capture && cap_sel == SEL_H)
				h_q <= mem_rdata;
			else if (op_fire && op.kind == OP_LDH)
				h_q <= op.data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cc_q <= CC_RESET;
		end else if (bus_wr && avs_address == REG_CC && avs_byteenable[0]) begin
			cc_q <= avs_writedata[7:0] | CC_FIXED;
		end else if (capture && cap_sel == SEL_CC) begin
			cc_q <= mem_rdata | CC_FIXED;
		end else if (issue && st_q == S_INT && k == INT_PUSHES) begin
			cc_q[CC_I] <= 1'b1;
		end else if (op_fire) begin
			unique case (op.kind)
				OP_ALU:    cc_q <= alu.cc | CC_FIXED;
				OP_LDX, OP_LDH: begin
					cc_q[CC_N] <= op.data[7];
					cc_q[CC_Z] <= (op.data == 8'h00);
					cc_q[CC_V] <= 1'b0;
				end
				OP_TAP:    cc_q <= acc_q | CC_FIXED;
				OP_SEI:    cc_q[CC_I] <= 1'b1;
				OP_INT_EN: cc_q[CC_I] <= 1'b0;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			sp_q <= SP_RESET;
		else if (bus_wr && avs_address == REG_SP)
			sp_q <= be16(sp_q, avs_writedata, avs_byteenable);
		else if (issue && is_wr)
			sp_q <= sp_q - 16'h0001;
		else if (issue && is_pull)
			sp_q <= sp_q + 16'h0001;
		else if (op_fire && op.kind == OP_SP_RESET)
			sp_q <= {sp_q[15:8], SP_LOW_SET};
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			pc_q <= PC_RESET;
		else if (bus_wr && avs_address == REG_PC)
			pc_q <= be16(pc_q, avs_writedata, avs_byteenable);
		else if (capture && cap_sel == SEL_PCH)
			pc_q[15:8] <= mem_rdata;
		else if (capture && cap_sel == SEL_PCL)
			pc_q[7:0] <= mem_rdata;
		else if (op_fire && op.kind == OP_FETCH)
			pc_q <= pc_q + 16'h0001;
		else if (op_fire && op.kind == OP_JUMP)
			pc_q <= op.addr;
		else if (op_fire && op.kind == OP_BRANCH && cond_f(op.cond, cc_q))
			pc_q <= pc_q + {{8{op.data[7]}}, op.data};
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			vec_q <= VEC_IRQ_TOP;
			ack_q <= 1'b0;
			idx_q <= '0;
		end else begin
			ack_q <= irq_go;
			if (irq_go) begin
				idx_q <= prio;
				vec_q <= VEC_IRQ_TOP - 16'({prio, 1'b0});
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			ea_q <= 16'h0000;
		else if (op_fire && op.kind == OP_EA_IX)
			ea_q <= {h_q, x_q} + op.addr;
		else if (op_fire && op.kind == OP_EA_SP)
			ea_q <= sp_q + op.addr;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mem_q <= '0;
		end else begin
			mem_q.rd <= issue && !is_wr;
			mem_q.wr <= issue && is_wr;
			if (issue) begin
				mem_q.addr <= iss_addr;
				mem_q.wdata <= iss_data;
			end
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign op_ready = ready_q;
	assign mem = mem_q;
	assign irq_ack = ack_q;
	assign irq_idx = idx_q;
	assign regs = '{acc: acc_q, hx: {h_q, x_q}, sp: sp_q, pc: pc_q,
		cc: cc_q};
	assign ea = ea_q;
endmodule : crsf_core
`default_nettype wire

/* File: verif/crsf_core_chk_asserts.sv */
/*
 * Checker for the register set core: reset, stack, flags, interrupts.
 * Assumes it is bound to crsf_core and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none
module crsf_core_chk import crsf_pkg::*; #(
	parameter int IRQ_N = 4,
	localparam int IW = $clog2(IRQ_N)
) (
	// Clock and reset
	input wire logic             sys_clk,
	input wire logic             rst_n,
	// Core side
	input wire crsf_op_t         op,
	input wire logic             op_valid,
	input wire logic             op_ready,
	input wire crsf_mem_req_t    mem,
	input wire logic [IRQ_N-1:0] irq_pend,
	input wire logic             irq_ack,
	input wire logic [IW-1:0]    irq_idx,
	input wire crsf_regs_t       regs,
	input wire logic [15:0]      ea
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic fire;
	assign fire = op_valid && op_ready;
	function automatic logic [IW-1:0] first_set(logic [IRQ_N-1:0] p);
		first_set = '0;
		for (int i = IRQ_N - 1; i >= 0; i--)
			if (p[i])
				first_set = IW'(i);
	endfunction : first_set
	property p_rst_vals;
		$rose(rst_n) |-> regs.sp == SP_RESET && regs.cc == CC_RESET;
	endproperty
	a_rst_vals: assert property (p_rst_vals)
		else $error("reset values");
	property p_vec;
		$rose(rst_n) |=> (mem.rd && mem.addr == VEC_RESET)
			##2 (mem.rd && mem.addr == 16'hffff);
	endproperty
	a_vec: assert property (p_vec)
		else $error("vector fetch");
	property p_fixed;
		regs.cc[6:5] == 2'b11;
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed bits");
	property p_rsp;
		fire && op.kind == OP_SP_RESET
			|=> regs.sp == {$past(regs.sp[15:8]), SP_LOW_SET};
	endproperty
	a_rsp: assert property (p_rsp)
		else $error("stack reset op");
	property p_ldx;
		fire && op.kind == OP_LDX
			|=> regs.hx == {$past(regs.hx[15:8]), $past(op.data)};
	endproperty
	a_ldx: assert property (p_ldx)
		else $error("index low load");
	property p_ea_sp;
		fire && op.kind == OP_EA_SP |=> ea == $past(regs.sp) + $past(op.addr);
	endproperty
	a_ea_sp: assert property (p_ea_sp)
		else $error("stack address");
	property p_ea_ix;
		fire && op.kind == OP_EA_IX |=> ea == $past(regs.hx) + $past(op.addr);
	endproperty
	a_ea_ix: assert property (p_ea_ix)
		else $error("index address");
	property p_nz;
		fire && op.kind == OP_ALU |=> regs.cc[CC_N] == regs.acc[7]
			&& regs.cc[CC_Z] == (regs.acc == 8'h00);
	endproperty
	a_nz: assert property (p_nz)
		else $error("sign or zero flag");
	property p_push;
		fire && op.kind == OP_PUSH && op.sel == SEL_A |-> ##2 mem.wr
			&& mem.addr == $past(regs.sp, 2) && mem.wdata == $past(regs.acc, 2);
	endproperty
	a_push: assert property (p_push)
		else $error("push write");
	property p_prio;
		irq_ack |-> !$past(regs.cc[CC_I]) && irq_idx == first_set($past(irq_pend));
	endproperty
	a_prio: assert property (p_prio)
		else $error("interrupt choice");
	property p_entry;
		irq_ack |-> ##10 !regs.cc[CC_I] ##1 (regs.cc[CC_I] && mem.rd
			&& mem.addr == VEC_IRQ_TOP - {irq_idx, 1'b0});
	endproperty
	a_entry: assert property (p_entry)
		else $error("entry order");
	property p_hx_keep;
		irq_ack |=> $stable(regs.hx) [*8];
	endproperty
	a_hx_keep: assert property (p_hx_keep)
		else $error("index moved");
	c_irq: cover property (irq_ack);
	c_pull: cover property (fire && op.kind == OP_PULL);
	c_ret: cover property (fire && op.kind == OP_RET_INT);
endmodule : crsf_core_chk
bind crsf_core crsf_core_chk #(.IRQ_N(IRQ_N)) i_chk (.sys_clk, .rst_n, .op,
	.op_valid, .op_ready, .mem, .irq_pend, .irq_ack, .irq_idx, .regs, .ea);
`default_nettype wire

/* File: verif/crsf_mem_model.sv */
/*
 * Byte memory answering core reads one cycle after the request.
 * Assumes one clock shared with the core; holds the vectors.
 */
`timescale 1ns/10ps
`default_nettype none
module crsf_mem_model import crsf_pkg::*; (
	// Clock
	input wire logic          sys_clk,
	// Core memory port
	input wire crsf_mem_req_t mem,
	output logic [7:0]        mem_rdata
);
	logic [7:0] ram_q [0:65535];
	initial begin
		ram_q[16'hfffe] = 8'h12;
		ram_q[16'hffff] = 8'h34;
		ram_q[16'hfffa] = 8'h56;
		ram_q[16'hfffb] = 8'h78;
	end
	// Outside a read the lines flip, so stale data never looks valid
	always @(posedge sys_clk) begin
		if (mem.wr === 1'b1)
			ram_q[mem.addr] <= mem.wdata;
		mem_rdata <= (mem.rd === 1'b1) ? ram_q[mem.addr] : ~mem_rdata;
	end
endmodule : crsf_mem_model
`default_nettype wire

/* File: verif/cpu_register_set_and_flags_bench.sv */
/*
 * Self-checking bench for the register set core.
 * Assumes the core, its checker and the memory model compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module cpu_register_set_and_flags_bench import crsf_pkg::*;;
	typedef struct packed {
		crsf_regs_t  r;
		logic [15:0] ea;
	} crsf_note_t;
	logic          sys_clk = 1'b0;
	logic          rst_n, avs_read, avs_write, avs_waitrequest;
	logic          op_valid, op_ready, irq_ack, fired;
	logic [2:0]    avs_address;
	logic [31:0]   avs_writedata, avs_readdata;
	logic [3:0]    avs_byteenable, irq_pend;
	crsf_op_t      op;
	crsf_mem_req_t mem;
	logic [7:0]    mem_rdata;
	logic [1:0]    irq_idx, e_idx;
	crsf_regs_t    regs;
	logic [15:0]   ea, s;
	crsf_note_t    e, keep;
	crsf_note_t    q_reg[$];
	logic [31:0]   q_rd[$];
	logic [23:0]   q_wr[$];
	int            n_fail, checks_done, seed;

	always #12.5 sys_clk = ~sys_clk;

	crsf_core #(.IRQ_N(4)) i_dut (.sys_clk, .rst_n, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .op, .op_valid, .op_ready, .mem, .mem_rdata,
		.irq_pend, .irq_ack, .irq_idx, .regs, .ea);
	crsf_mem_model i_mem (.sys_clk, .mem, .mem_rdata);

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	task automatic tally(logic ok, string m);
		checks_done++;
		if (!ok) begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : tally
	task automatic cmp_regs(crsf_note_t g, crsf_note_t x);
		tally(g === x, "register view");
	endtask : cmp_regs
	task automatic cmp_rd(logic [31:0] g, logic [31:0] x);
		tally(g === x, "bus read data");
	endtask : cmp_rd
	task automatic cmp_wr(logic [23:0] g, logic [23:0] x);
		tally(g === x, "memory write");
	endtask : cmp_wr
	task automatic cmp_idx(logic [1:0] g, logic [1:0] x);
		tally(g === x, "interrupt index");
	endtask : cmp_idx
	// Each wait is bounded; running out ends the run
	task automatic wait_for(int w);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (n > 500) begin
				n_fail++;
				end_of_test();
			end
		end while (!(w == 0 ? op_ready === 1'b1 :
			w == 1 ? avs_waitrequest === 1'b0 : irq_ack === 1'b1));
	endtask : wait_for
	task automatic bus(logic w, logic [2:0] a, logic [31:0] d, logic [3:0] be);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		wait_for(1);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic rd(logic [2:0] a, logic [31:0] x);
		q_rd.push_back(x);
		bus(1'b0, a, 32'h0, 4'hf);
	endtask : rd
	task automatic do_op(crsf_kind_t k, logic [7:0] d, logic [15:0] a,
		crsf_sel_t sl = SEL_A, crsf_cond_t c = COND_ALWAYS,
		crsf_fn_t f = FN_ADD);
		q_reg.push_back(e);
		op <= '{k, f, c, sl, d, a};
		op_valid <= 1'b1;
		wait_for(0);
		op_valid <= 1'b0;
		@(posedge sys_clk);
	endtask : do_op
	task automatic load_x(logic hi, logic [7:0] d);
		if (hi)
			e.r.hx[15:8] = d;
		else
			e.r.hx[7:0] = d;
		e.r.cc[CC_V] = 1'b0;
		e.r.cc[CC_N] = d[7];
		e.r.cc[CC_Z] = d == 8'h00;
		do_op(hi ? OP_LDH : OP_LDX, d, 16'h0);
	endtask : load_x
	task automatic arith(logic [7:0] b, logic sub);
		logic [8:0] r;
		logic [7:0] a;
		a = e.r.acc;
		r = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
		e.r.acc = r[7:0];
		e.r.cc[CC_V] = (a[7] == (b[7] ^ sub)) && (r[7] != a[7]);
		if (!sub)
			e.r.cc[CC_H] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
		e.r.cc[CC_N] = r[7];
		e.r.cc[CC_Z] = r[7:0] == 8'h00;
		e.r.cc[CC_C] = r[8];
		do_op(OP_ALU, b, 16'h0, SEL_A, COND_ALWAYS, sub ? FN_SUB : FN_ADD);
	endtask : arith

	// Result monitor: oldest note against what appears
	always @(posedge sys_clk) begin
		if (fired === 1'b1)
			cmp_regs({regs, ea}, q_reg.pop_front());
		fired <= op_valid && op_ready;
		if (avs_read && avs_waitrequest === 1'b0)
			cmp_rd(avs_readdata, q_rd.pop_front());
		if (mem.wr === 1'b1)
			cmp_wr({mem.addr, mem.wdata}, q_wr.pop_front());
		if (irq_ack === 1'b1)
			cmp_idx(irq_idx, e_idx);
	end

	initial begin
		seed = 32'hfbc1;
		{rst_n, avs_read, avs_write, op_valid, fired} = '0;
		{avs_address, avs_writedata, avs_byteenable, irq_pend} = '0;
		op = '0;
		n_fail = 0;
		checks_done = 0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		wait_for(0);
		e = '{'{8'h00, 16'h0000, SP_RESET, 16'h1234, CC_RESET}, 16'h0000};
		do_op(OP_NOP, 8'h0, 16'h0);
		rd(3'h4, 32'h0000_00ff);
		bus(1'b1, 3'h0, 32'h7f, 4'h1);
		bus(1'b1, 3'h7, 32'h55, 4'hf);
		rd(3'h7, 32'h0);
		rd(3'h0, 32'h7f);
		e.r.acc = 8'h7f;
		bus(1'b1, 3'h3, 32'h08, 4'h1);
		rd(3'h3, 32'h68);
		load_x(1'b0, 8'h5a);
		load_x(1'b1, 8'ha5);
		e.ea = 16'ha56a;
		do_op(OP_EA_IX, 8'h0, 16'h0010);
		e.ea = 16'h0102;
		do_op(OP_EA_SP, 8'h0, 16'h0003);
		e.r.pc = 16'h2000;
		do_op(OP_JUMP, 8'h0, 16'h2000);
		e.r.pc = 16'h2001;
		do_op(OP_FETCH, 8'h0, 16'h0);
		arith(8'h01, 1'b0);
		do_op(OP_BRANCH, 8'h10, 16'h0, SEL_A, COND_SIGNED_LESS);
		e.r.pc = 16'h1ff1;
		do_op(OP_BRANCH, 8'hf0, 16'h0, SEL_A,
			COND_SIGNED_GREATER);
		repeat (6) arith(8'($random(seed)), 1'b0);
		repeat (2) arith(8'($random(seed)), 1'b1);
		arith(e.r.acc, 1'b1);
		// 19 + 28 carries out of the low digit; adjust gives 47
		arith(8'h19, 1'b0);
		arith(8'h28, 1'b0);
		e.r.acc = 8'h47;
		e.r.cc[CC_N] = 1'b0;
		e.r.cc[CC_Z] = 1'b0;
		e.r.cc[CC_C] = 1'b0;
		do_op(OP_ALU, 8'h0, 16'h0, SEL_A, COND_ALWAYS, FN_DADJ);
		rd(3'h3, {24'h0, e.r.cc});
		bus(1'b1, 3'h0, 32'h9f, 4'h1);
		e.r.acc = 8'h9f;
		e.r.cc = 8'hff;
		do_op(OP_TAP, 8'h0, 16'h0);
		bus(1'b1, 3'h4, 32'h0140, 4'h3);
		e.r.sp = 16'h01ff;
		do_op(OP_SP_RESET, 8'h0, 16'h0);
		bus(1'b1, 3'h4, 32'h0180, 4'h3);
		e.r.sp = 16'h0180;
		q_wr.push_back({16'h0180, 8'h9f});
		do_op(OP_PUSH, 8'h0, 16'h0);
		e.r.sp = 16'h017f;
		do_op(OP_PULL, 8'h0, 16'h0, SEL_X);
		e.r.sp = 16'h0180;
		e.r.hx[7:0] = 8'h9f;
		do_op(OP_NOP, 8'h0, 16'h0);
		load_x(1'b1, 8'h33);
		// Two requests pending; the lower index wins
		e.r.cc[CC_I] = 1'b0;
		e_idx = 2'd1;
		s = e.r.sp;
		q_wr.push_back({s, e.r.pc[7:0]});
		q_wr.push_back({s - 16'h1, e.r.pc[15:8]});
		q_wr.push_back({s - 16'h2, e.r.hx[7:0]});
		q_wr.push_back({s - 16'h3, e.r.acc});
		q_wr.push_back({s - 16'h4, e.r.cc});
		keep = e;
		irq_pend <= 4'b0110;
		do_op(OP_INT_EN, 8'h0, 16'h0);
		wait_for(2);
		irq_pend <= 4'b0000;
		e.r.sp = s - 16'h5;
		e.r.cc[CC_I] = 1'b1;
		e.r.pc = 16'h5678;
		do_op(OP_NOP, 8'h0, 16'h0);
		do_op(OP_RET_INT, 8'h0, 16'h0);
		e = keep;
		do_op(OP_NOP, 8'h0, 16'h0);
		e.r.cc[CC_I] = 1'b1;
		do_op(OP_SEI, 8'h0, 16'h0);
		irq_pend <= 4'b1000;
		repeat (30) @(posedge sys_clk);
		irq_pend <= 4'b0000;
		do_op(OP_NOP, 8'h0, 16'h0);
		@(posedge sys_clk);
		tally(q_reg.size() + q_wr.size() + q_rd.size() == 0,
			"notes left");
		end_of_test();
	end
endmodule : cpu_register_set_and_flags_bench
`default_nettype wire
